// [src/alu_pkg.sv]
// Package of constants and types for the ALU datapath
// Contract
// - 16-bit ALU: add, subtract, shift, logic
// - Arithmetic is two's complement
// - Operations update C, Z, N, OV, DC flags; add/sub update all five, shifts C, Z, N, logic and divide Z, N, MUL none
// - Subtraction: carry is inverted borrow, DC inverted digit borrow
// - Byte or word width per instruction
// - Operands from register array or memory; the divide divisor comes from reg_b_i on the decode port, from opb_r for software issue
// - Result goes to register array or memory
// - Hardware multiplier plus 16-bit divisor support
// - 17x17 multiplier, unsigned, signed, mixed
// - Word products: s*s, u*u, u*s
// - Word times unsigned 5-bit literal
// - Unsigned byte by byte multiply
package alu_pkg;

	// ==========================================
	// Widths
	localparam int WORD_W = 16;
	localparam int BYTE_W = 8;
	localparam int MUL_W = 17;
	localparam int PROD_W = 32;
	localparam int LIT_W = 5;

	// ==========================================
	// Wishbone register map (word addresses, byte offsets)
	localparam logic [3:0] REG_OPA = 4'h0;
	localparam logic [3:0] REG_OPB = 4'h4;
	localparam logic [3:0] REG_CTRL = 4'h8;
	localparam logic [3:0] REG_FLAGS = 4'hc;

	// Control register field positions
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_OP_W = 4;
	localparam int CTRL_BYTE_BIT = 4;
	localparam int CTRL_CIN_BIT = 5;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;

	// Status flag bit positions
	localparam int FLG_C = 0;
	localparam int FLG_Z = 1;
	localparam int FLG_OV = 2;
	localparam int FLG_N = 3;
	localparam int FLG_DC = 4;
	localparam logic [4:0] FLAGS_RST = 5'h00;

	// Divide-step count: one step per divisor bit
	localparam logic [4:0] DIV_STEPS = 5'h10;

	// ==========================================
	// Operation codes
	typedef enum logic [3:0] {
		OP_ADD = 4'h0, OP_ADDC = 4'h1, OP_SUB = 4'h2, OP_SUBB = 4'h3,
		OP_AND = 4'h4, OP_IOR = 4'h5, OP_XOR = 4'h6, OP_SHL = 4'h7,
		OP_SHR = 4'h8, OP_ASR = 4'h9, OP_MUL = 4'ha, OP_DIVU = 4'hb,
		OP_DIVS = 4'hc
	} alu_op_t;

	// Multiplier signedness modes
	typedef enum logic [2:0] {
		MUL_SS = 3'h0, MUL_UU = 3'h1, MUL_US = 3'h2, MUL_SLIT = 3'h3,
		MUL_ULIT = 3'h4, MUL_BYTE = 3'h5
	} mul_mode_t;

	// Operand source and result destination
	typedef enum logic {SRC_REG = 1'b0, SRC_MEM = 1'b1} src_sel_t;

endpackage : alu_pkg

// [src/alu_multiplier.sv]
// 17 x 17 signed multiplier array with mode-driven operand extension
`timescale 1ns/1ns
module alu_multiplier import alu_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WORD_W-1:0] a_i,
	input wire logic [WORD_W-1:0] b_i,
	input wire logic [LIT_W-1:0] lit_i,
	input wire mul_mode_t mode_i,
	output logic [PROD_W-1:0] prod_o
);

	// ==========================================
	// Operand extension
	function automatic logic [MUL_W-1:0] ext17(input logic [WORD_W-1:0] v, input logic sgn);
		ext17 = {sgn & v[WORD_W-1], v};
	endfunction : ext17

	wire logic a_signed = (mode_i == MUL_SS) || (mode_i == MUL_SLIT);
	wire logic b_signed = (mode_i == MUL_SS) || (mode_i == MUL_US);
	wire logic lit_mode = (mode_i == MUL_SLIT) || (mode_i == MUL_ULIT);
	wire logic byte_mode = (mode_i == MUL_BYTE);
	wire logic [WORD_W-1:0] a_sel = byte_mode ? {8'h00, a_i[BYTE_W-1:0]} : a_i;
	wire logic [WORD_W-1:0] b_sel = lit_mode ? {11'h000, lit_i} :
		(byte_mode ? {8'h00, b_i[BYTE_W-1:0]} : b_i);
	wire logic signed [MUL_W-1:0] a_x = ext17(a_sel, a_signed);
	wire logic signed [MUL_W-1:0] b_x = ext17(b_sel, b_signed & ~lit_mode & ~byte_mode);
	wire logic signed [2*MUL_W-1:0] full = a_x * b_x;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prod_o <= '0;
		end else begin
			prod_o <= full[PROD_W-1:0];
		end
	end

endmodule : alu_multiplier

// [src/alu_divider.sv]
// Restoring divide engine, 32-bit dividend by 16-bit divisor
`timescale 1ns/1ns
module alu_divider import alu_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic signed_i,
	input wire logic [PROD_W-1:0] dividend_i,
	input wire logic [WORD_W-1:0] divisor_i,
	output logic busy_o,
	output logic done_o,
	output logic [WORD_W-1:0] quot_o,
	output logic [WORD_W-1:0] rem_o
);

	typedef enum logic {D_IDLE, D_RUN} div_state_t;
	div_state_t state_r;
	logic [4:0] cnt_r;
	logic [WORD_W:0] rem_r;
	logic [PROD_W-1:0] num_r;
	logic [WORD_W-1:0] dvs_r;
	logic negq_r, negr_r;

	wire logic n_neg = signed_i & dividend_i[PROD_W-1];
	wire logic d_neg = signed_i & divisor_i[WORD_W-1];
	wire logic [PROD_W-1:0] n_abs = n_neg ? (~dividend_i + 32'h1) : dividend_i;
	wire logic [WORD_W-1:0] d_abs = d_neg ? (~divisor_i + 16'h1) : divisor_i;
	wire logic [WORD_W:0] trial = {rem_r[WORD_W-1:0], num_r[PROD_W-1]};
	wire logic [WORD_W:0] diff = trial - {1'b0, dvs_r};
	wire logic fits = ~diff[WORD_W];
	wire logic last = (cnt_r == 5'h01);
	// Dividend bits leave at the top while quotient bits enter at the bottom
	wire logic [PROD_W-1:0] num_next = {num_r[PROD_W-2:0], fits};
	wire logic [WORD_W-1:0] q_next = num_next[WORD_W-1:0];
	wire logic [WORD_W-1:0] r_next = fits ? diff[WORD_W-1:0] : trial[WORD_W-1:0];

	assign busy_o = (state_r == D_RUN);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= D_IDLE;
			cnt_r <= '0;
			rem_r <= '0;
			num_r <= '0;
			dvs_r <= '0;
			negq_r <= 1'b0;
			negr_r <= 1'b0;
			done_o <= 1'b0;
			quot_o <= '0;
			rem_o <= '0;
		end else begin
			done_o <= 1'b0;
			case (state_r)
				D_IDLE: begin
					if (start_i) begin
						rem_r <= {1'b0, n_abs[PROD_W-1:WORD_W]};
						num_r <= {n_abs[WORD_W-1:0], 16'h0000};
						dvs_r <= d_abs;
						negq_r <= n_neg ^ d_neg;
						negr_r <= n_neg;
						cnt_r <= DIV_STEPS;
						state_r <= D_RUN;
					end
				end
				D_RUN: begin
					rem_r <= {1'b0, r_next};
					num_r <= num_next;
					cnt_r <= cnt_r - 5'h01;
					if (last) begin
						quot_o <= negq_r ? (~q_next + 16'h1) : q_next;
						rem_o <= negr_r ? (~r_next + 16'h1) : r_next;
						done_o <= 1'b1;
						state_r <= D_IDLE;
					end
				end
				default: state_r <= D_IDLE;
			endcase
		end
	end

endmodule : alu_divider

// [src/alu_core.sv]
// ALU datapath top: decode-side ports, Wishbone register window, flags
`timescale 1ns/1ns
module alu_core import alu_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic op_valid_i,
	input wire logic [3:0] op_i,
	input wire logic byte_mode_i,
	input wire logic [2:0] mul_mode_i,
	input wire logic [LIT_W-1:0] lit_i,
	input wire logic src_a_i,
	input wire logic src_b_i,
	input wire logic dst_i,
	input wire logic [WORD_W-1:0] reg_a_i,
	input wire logic [WORD_W-1:0] reg_b_i,
	input wire logic [WORD_W-1:0] mem_a_i,
	input wire logic [WORD_W-1:0] mem_b_i,
	output logic result_valid_o,
	output logic [WORD_W-1:0] result_o,
	output logic [WORD_W-1:0] result_hi_o,
	output logic result_to_reg_o,
	output logic result_to_mem_o,
	output logic busy_o,
	output logic [4:0] status_flags_register_o,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	output logic wb_err_o
);

	// ==========================================
	// Register window
	logic [WORD_W-1:0] opa_r, opb_r;
	logic [31:0] ctrl_r;
	logic [4:0] flags_r, flags_nxt;
	logic ack_r;
	logic [31:0] rdat_r;

	logic err_r;
	wire logic wb_req = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;
	wire logic hit_opa = (wb_adr_i[3:0] == REG_OPA);
	wire logic hit_opb = (wb_adr_i[3:0] == REG_OPB);
	wire logic hit_ctrl = (wb_adr_i[3:0] == REG_CTRL);
	wire logic hit_flags = (wb_adr_i[3:0] == REG_FLAGS);
	wire logic mapped = (wb_adr_i[31:4] == 28'h0) & (hit_opa | hit_opb | hit_ctrl | hit_flags);
	wire logic wb_wr = wb_req & wb_we_i & mapped;
	wire logic sw_go = wb_wr & hit_ctrl & wb_sel_i[0];

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction : merge

	wire logic [31:0] opa_m = merge({16'h0, opa_r}, wb_dat_i, wb_sel_i);
	wire logic [31:0] opb_m = merge({16'h0, opb_r}, wb_dat_i, wb_sel_i);
	wire logic [31:0] ctrl_m = merge(ctrl_r, wb_dat_i, wb_sel_i);
	wire logic [31:0] rd_mux = hit_opa ? {16'h0, opa_r} : hit_opb ? {16'h0, opb_r} :
		hit_ctrl ? {26'h0, ctrl_r[5:0]} : {26'h0, busy_o, flags_r};

	// ==========================================
	// Operation issue: decode port has priority over software
	wire logic issue_dec = op_valid_i & ~busy_o;
	wire logic issue_sw = sw_go & ~op_valid_i & ~busy_o;
	wire logic issue = issue_dec | issue_sw;
	wire logic [3:0] op_sel = issue_dec ? op_i : ctrl_m[CTRL_OP_LSB +: CTRL_OP_W];
	wire logic bmode = issue_dec ? byte_mode_i : ctrl_m[CTRL_BYTE_BIT];
	wire logic [WORD_W-1:0] a_in = issue_dec ? (src_a_i ? mem_a_i : reg_a_i) : opa_r;
	wire logic [WORD_W-1:0] b_in = issue_dec ? (src_b_i ? mem_b_i : reg_b_i) : opb_r;
	wire logic cin = issue_dec ? flags_r[FLG_C] : ctrl_m[CTRL_CIN_BIT];

	// ==========================================
	// Adder, logic and shifter
	wire logic is_sub = (op_sel == OP_SUB) || (op_sel == OP_SUBB);
	wire logic use_c = (op_sel == OP_ADDC) || (op_sel == OP_SUBB);
	wire logic [WORD_W-1:0] b_eff = is_sub ? ~b_in : b_in;
	wire logic c0 = use_c ? cin : is_sub;
	wire logic [WORD_W:0] sum = {1'b0, a_in} + {1'b0, b_eff} + {16'h0, c0};
	wire logic [4:0] nib = {1'b0, a_in[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c0};
	wire logic [BYTE_W:0] bsum = {1'b0, a_in[7:0]} + {1'b0, b_eff[7:0]} + {8'h0, c0};
	wire logic msb_a = bmode ? a_in[7] : a_in[15];
	wire logic msb_b = bmode ? b_eff[7] : b_eff[15];
	wire logic msb_r = bmode ? bsum[7] : sum[15];
	wire logic [WORD_W-1:0] shl = {a_in[14:0], 1'b0};
	wire logic [WORD_W-1:0] shr = bmode ? {8'h0, 1'b0, a_in[7:1]} : {1'b0, a_in[15:1]};
	wire logic [WORD_W-1:0] asr = bmode ? {8'h0, a_in[7], a_in[7:1]} : {a_in[15], a_in[15:1]};

	logic [WORD_W-1:0] res;
	logic c_new, ov_new, dc_new;
	logic upd_c, upd_ov;
	always_comb begin
		res = sum[WORD_W-1:0];
		c_new = flags_r[FLG_C];
		ov_new = flags_r[FLG_OV];
		dc_new = flags_r[FLG_DC];
		upd_c = 1'b0;
		upd_ov = 1'b0;
		case (op_sel)
			OP_ADD, OP_ADDC, OP_SUB, OP_SUBB: begin
				c_new = bmode ? bsum[BYTE_W] : sum[WORD_W];
				dc_new = nib[4];
				ov_new = (msb_a == msb_b) && (msb_r != msb_a);
				upd_c = 1'b1;
				upd_ov = 1'b1;
			end
			OP_AND: res = a_in & b_in;
			OP_IOR: res = a_in | b_in;
			OP_XOR: res = a_in ^ b_in;
			OP_SHL: begin
				res = shl;
				c_new = bmode ? a_in[7] : a_in[15];
				upd_c = 1'b1;
			end
			OP_SHR, OP_ASR: begin
				res = (op_sel == OP_SHR) ? shr : asr;
				c_new = a_in[0];
				upd_c = 1'b1;
			end
			default: res = sum[WORD_W-1:0];
		endcase
	end

	wire logic [WORD_W-1:0] res_w = bmode ? {8'h0, res[7:0]} : res;
	wire logic z_new = bmode ? (res[7:0] == 8'h0) : (res == 16'h0);
	wire logic n_new = bmode ? res[7] : res[15];

	// ==========================================
	// Multiplier and divider
	wire logic is_mul = (op_sel == OP_MUL);
	wire logic is_div = (op_sel == OP_DIVU) || (op_sel == OP_DIVS);
	logic [PROD_W-1:0] prod;
	logic div_busy, div_done;
	logic [WORD_W-1:0] quot, rem;
	logic mul_pend_r, dst_r;

	alu_multiplier u_mul (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.a_i(a_in),
		.b_i(b_in),
		.lit_i(lit_i),
		.mode_i(mul_mode_t'(issue_dec ? mul_mode_i : ctrl_m[10:8])),
		.prod_o(prod)
	);

	alu_divider u_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(issue & is_div),
		.signed_i(op_sel == OP_DIVS),
		.dividend_i({b_in, a_in}),
		.divisor_i(issue_dec ? reg_b_i : opb_r),
		.busy_o(div_busy),
		.done_o(div_done),
		.quot_o(quot),
		.rem_o(rem)
	);

	// Registered terms only, so issue never loops back through busy
	assign busy_o = div_busy | div_done | mul_pend_r;
	assign status_flags_register_o = flags_r;
	assign result_to_reg_o = result_valid_o & ~dst_r;
	assign result_to_mem_o = result_valid_o & dst_r;
	assign wb_ack_o = ack_r;
	assign wb_err_o = err_r;

	// ==========================================
	// Flag update
	always_comb begin
		flags_nxt = flags_r;
		if (issue & ~is_mul & ~is_div) begin
			flags_nxt[FLG_Z] = z_new;
			flags_nxt[FLG_N] = n_new;
			if (upd_c) flags_nxt[FLG_C] = c_new;
			if (upd_ov) flags_nxt[FLG_OV] = ov_new;
			if (upd_ov) flags_nxt[FLG_DC] = dc_new;
		end else if (div_done) begin
			flags_nxt[FLG_Z] = (quot == 16'h0);
			flags_nxt[FLG_N] = quot[15];
		end else if (wb_wr & hit_flags & wb_sel_i[0]) begin
			flags_nxt = wb_dat_i[4:0];
		end
	end

	// ==========================================
	// Sequential state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			opa_r <= '0;
			opb_r <= '0;
			ctrl_r <= CTRL_RST;
			flags_r <= FLAGS_RST;
			ack_r <= 1'b0;
			err_r <= 1'b0;
			rdat_r <= '0;
			mul_pend_r <= 1'b0;
			dst_r <= 1'b0;
			result_valid_o <= 1'b0;
			result_o <= '0;
			result_hi_o <= '0;
		end else begin
			ack_r <= wb_req & mapped;
			err_r <= wb_req & ~mapped;
			rdat_r <= rd_mux;
			flags_r <= flags_nxt;
			if (wb_wr & hit_opa) opa_r <= opa_m[WORD_W-1:0];
			if (wb_wr & hit_opb) opb_r <= opb_m[WORD_W-1:0];
			if (wb_wr & hit_ctrl) ctrl_r <= ctrl_m;
			if (issue) dst_r <= issue_dec ? dst_i : 1'b0;
			mul_pend_r <= issue & is_mul;
			result_valid_o <= 1'b0;
			if (issue & ~is_mul & ~is_div) begin
				result_valid_o <= 1'b1;
				result_o <= res_w;
				result_hi_o <= '0;
			end else if (mul_pend_r) begin
				result_valid_o <= 1'b1;
				result_o <= prod[WORD_W-1:0];
				result_hi_o <= prod[PROD_W-1:WORD_W];
			end else if (div_done) begin
				result_valid_o <= 1'b1;
				result_o <= quot;
				result_hi_o <= rem;
			end
		end
	end

	assign wb_dat_o = rdat_r;

	// ==========================================
	// Checks
	zero_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		issue & ~is_mul & ~is_div |=> flags_r[FLG_Z] == (result_o == 16'h0))
		else $error("zero flag mismatch");
	byte_width_a: assert property (@(posedge clk_i) disable iff (rst_i)
		issue & bmode & ~is_mul & ~is_div |=> result_o[15:8] == 8'h00)
		else $error("byte result high bits set");
	mul_latency_a: assert property (@(posedge clk_i) disable iff (rst_i)
		issue & is_mul |=> ##1 result_valid_o)
		else $error("multiply result late");
	div_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
		issue & is_div |-> ##[1:20] div_done)
		else $error("divide did not finish");
	sub_borrow_a: assert property (@(posedge clk_i) disable iff (rst_i)
		issue_dec & (op_i == OP_SUB) & ~byte_mode_i & (a_in >= b_in) |=> flags_r[FLG_C])
		else $error("borrow flag wrong");
	dest_excl_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!(result_to_reg_o && result_to_mem_o))
		else $error("two destinations");
	wb_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_cyc_i & wb_stb_i & ~ack_r & ~err_r |=> ack_r | err_r)
		else $error("bus not answered");
	neg_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		issue & ~bmode & ~is_mul & ~is_div |=> flags_r[FLG_N] == result_o[15])
		else $error("negative flag mismatch");
	cov_add_c: cover property (@(posedge clk_i) issue & (op_sel == OP_ADD) & c_new);
	cov_mul_c: cover property (@(posedge clk_i) issue & is_mul);
	cov_div_c: cover property (@(posedge clk_i) div_done);
	cov_byte_c: cover property (@(posedge clk_i) issue & bmode);

endmodule : alu_core

// [verif/decode_model.sv]
// Behavioural decoder and register-file partner that feeds and receives the ALU
`timescale 1ns/1ns
module decode_model import alu_pkg::*; (
	input wire logic clk_i,
	input wire logic ld_i,
	input wire logic [WORD_W-1:0] ld_w0_i,
	input wire logic [WORD_W-1:0] ld_w1_i,
	input wire logic [WORD_W-1:0] ld_m0_i,
	input wire logic [WORD_W-1:0] ld_m1_i,
	input wire logic result_valid_i,
	input wire logic [WORD_W-1:0] result_i,
	input wire logic to_reg_i,
	input wire logic to_mem_i,
	output logic [WORD_W-1:0] reg_a_o,
	output logic [WORD_W-1:0] reg_b_o,
	output logic [WORD_W-1:0] mem_a_o,
	output logic [WORD_W-1:0] mem_b_o
);
	// ==========================================
	// Working registers and data memory words
	logic [WORD_W-1:0] w_r [2] = '{16'h0000, 16'h0000};
	logic [WORD_W-1:0] m_r [2] = '{16'h0000, 16'h0000};
	// Both sources offered, the addressing mode picks one
	assign reg_a_o = w_r[0];
	assign reg_b_o = w_r[1];
	assign mem_a_o = m_r[0];
	assign mem_b_o = m_r[1];
	// ==========================================
	// Operand load and result write-back
	always @(posedge clk_i) begin
		if (ld_i) begin
			w_r[0] <= ld_w0_i;
			w_r[1] <= ld_w1_i;
			m_r[0] <= ld_m0_i;
			m_r[1] <= ld_m1_i;
		end else if (result_valid_i) begin
			if (to_reg_i) begin
				w_r[0] <= result_i;
			end
			if (to_mem_i) begin
				m_r[0] <= result_i;
			end
		end
	end
endmodule : decode_model

// [verif/test_cpu_alu_with_multiplier.sv]
// Self-checking bench for the ALU datapath with multiplier and divider
`timescale 1ns/1ns
module test_cpu_alu_with_multiplier import alu_pkg::*; ;
	// ==========================================
	// Signals
	logic clk_i = 1'h0, rst_i = 1'h1, op_valid_i = 1'h0, byte_mode_i = 1'h0, ld = 1'h0;
	logic src_a_i = 1'h0, src_b_i = 1'h0, dst_i = 1'h0, wb_we_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
	logic [3:0] op_i = 4'h0, wb_sel_i = 4'h0;
	logic [2:0] mul_mode_i = 3'h0;
	logic [LIT_W-1:0] lit_i = 5'h00;
	logic [WORD_W-1:0] ld_w0 = 16'h0000, ld_w1 = 16'h0000, ld_m0 = 16'h0000, ld_m1 = 16'h0000;
	logic [WORD_W-1:0] reg_a, reg_b, mem_a, mem_b, result_o, result_hi_o, last_res;
	logic result_valid_o, result_to_reg_o, result_to_mem_o, busy_o, wb_ack_o, wb_err_o;
	logic saw_busy, to_mem, last_reg, err;
	logic [4:0] flags;
	logic [31:0] wb_adr_i = 32'h0000_0000, wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
	int mismatches = 0, checks_done = 0, lat, n_res = 0;
	always #50 clk_i = ~clk_i;
	alu_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .op_i(op_i), .byte_mode_i(byte_mode_i),
		.mul_mode_i(mul_mode_i), .lit_i(lit_i), .src_a_i(src_a_i), .src_b_i(src_b_i), .dst_i(dst_i),
		.reg_a_i(reg_a), .reg_b_i(reg_b), .mem_a_i(mem_a), .mem_b_i(mem_b), .result_valid_o(result_valid_o),
		.result_o(result_o), .result_hi_o(result_hi_o), .result_to_reg_o(result_to_reg_o),
		.result_to_mem_o(result_to_mem_o), .busy_o(busy_o), .status_flags_register_o(flags),
		.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o));
	decode_model i_part (.clk_i(clk_i), .ld_i(ld), .ld_w0_i(ld_w0), .ld_w1_i(ld_w1), .ld_m0_i(ld_m0),
		.ld_m1_i(ld_m1), .result_valid_i(result_valid_o), .result_i(result_o), .to_reg_i(result_to_reg_o),
		.to_mem_i(result_to_mem_o), .reg_a_o(reg_a), .reg_b_o(reg_b), .mem_a_o(mem_a), .mem_b_o(mem_b));
	// ==========================================
	// Result monitor for software-started operations
	always @(posedge clk_i) begin
		if (result_valid_o === 1'h1) begin
			n_res <= n_res + 1;
			last_res <= result_o;
			last_reg <= result_to_reg_o;
		end
	end
	// ==========================================
	// Reporting and comparison
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out
	task automatic give_up(input string nm);
		mismatches++;
		$display("CHECK FAILED %s expected answer seen none", nm);
		close_out();
	endtask : give_up
	task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_word
	task automatic chk_flags(input string nm, input logic [4:0] e, input logic [4:0] g, input logic [4:0] m);
		checks_done++;
		if ((g & m) !== (e & m)) begin
			mismatches++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e & m, g);
		end
	endtask : chk_flags
	// ==========================================
	// Bus and decode-port drivers
	task automatic run_op(input logic [3:0] op, input logic [3:0] cfg, input logic [2:0] mm, input logic [4:0] lt,
		input logic [15:0] w0, w1, m0, m1);
		@(posedge clk_i);
		ld <= 1'h1;
		ld_w0 <= w0;
		ld_w1 <= w1;
		ld_m0 <= m0;
		ld_m1 <= m1;
		@(posedge clk_i);
		ld <= 1'h0;
		op_valid_i <= 1'h1;
		op_i <= op;
		{byte_mode_i, src_a_i, src_b_i, dst_i} <= cfg;
		mul_mode_i <= mm;
		lit_i <= lt;
		@(posedge clk_i);
		op_valid_i <= 1'h0;
		@(negedge clk_i);
		saw_busy = busy_o;
		for (lat = 1; lat < 40 && result_valid_o !== 1'h1; lat++) begin
			@(negedge clk_i);
		end
		if (lat == 40) give_up("result valid");
		to_mem = result_to_mem_o;
	endtask : run_op
	task automatic wb_xfer(input logic [31:0] adr, input logic we, input logic [31:0] dat, input logic [3:0] sel);
		@(posedge clk_i);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_adr_i <= adr;
		wb_we_i <= we;
		wb_dat_i <= dat;
		wb_sel_i <= sel;
		for (int n = 0; n < 20; n++) begin
			@(posedge clk_i);
			if (wb_ack_o === 1'h1 || wb_err_o === 1'h1) begin
				rd = wb_dat_o;
				err = wb_err_o;
				wb_cyc_i <= 1'h0;
				wb_stb_i <= 1'h0;
				return;
			end
		end
		give_up("bus answer");
	endtask : wb_xfer
	// ==========================================
	// Scenarios
	task automatic t_arith();
		run_op(OP_ADD, 4'h0, 3'h0, 5'h00, 16'h7fff, 16'h0001, 16'h0000, 16'h0000);
		chk_word("add sum", 16'h8000, result_o);
		chk_flags("add flags", 5'h1c, flags, 5'h1f);
		chk_word("alu latency", 16'h0001, 16'(lat));
		run_op(OP_SUB, 4'h0, 3'h0, 5'h00, 16'h0000, 16'h0001, 16'h0000, 16'h0000);
		chk_word("sub diff", 16'hffff, result_o);
		chk_flags("sub flags", 5'h08, flags, 5'h1f);
		run_op(OP_SUB, 4'h0, 3'h0, 5'h00, 16'h0005, 16'h0003, 16'h0000, 16'h0000);
		chk_word("sub no borrow", 16'h0002, result_o);
		chk_flags("no borrow flags", 5'h11, flags, 5'h1f);
		run_op(OP_ADD, 4'h0, 3'h0, 5'h00, 16'hffff, 16'h0001, 16'h0000, 16'h0000);
		chk_flags("wrap flags", 5'h13, flags, 5'h1f);
		run_op(OP_ADDC, 4'h0, 3'h0, 5'h00, 16'h0001, 16'h0001, 16'h0000, 16'h0000);
		chk_word("addc sum", 16'h0003, result_o);
		chk_flags("addc flags", 5'h00, flags, 5'h1f);
		run_op(OP_SUBB, 4'h0, 3'h0, 5'h00, 16'h0005, 16'h0002, 16'h0000, 16'h0000);
		chk_word("subb diff", 16'h0002, result_o);
		chk_flags("subb flags", 5'h11, flags, 5'h1f);
		run_op(OP_ADD, 4'h8, 3'h0, 5'h00, 16'h12ff, 16'h3401, 16'h0000, 16'h0000);
		chk_word("byte sum", 16'h0000, result_o);
		chk_flags("byte wrap flags", 5'h13, flags, 5'h1f);
		run_op(OP_ADD, 4'h8, 3'h0, 5'h00, 16'h007f, 16'h0001, 16'h0000, 16'h0000);
		chk_flags("byte sign flags", 5'h1c, flags, 5'h1f);
		$display("arithmetic test done");
	endtask : t_arith
	task automatic t_logic();
		alu_op_t ops [6] = '{OP_AND, OP_IOR, OP_XOR, OP_SHL, OP_SHR, OP_ASR};
		logic [15:0] ex [6] = '{16'hf000, 16'hfff1, 16'h0ff1, 16'he1e2, 16'h7878, 16'hf878};
		logic [4:0] fl [6] = '{5'h08, 5'h08, 5'h00, 5'h08, 5'h00, 5'h08};
		for (int i = 0; i < 6; i++) begin
			run_op(ops[i], 4'h7, 3'h0, 5'h00, 16'h1234, 16'h5678, 16'hf0f1, 16'hff00);
			chk_word("logic result", ex[i], result_o);
			chk_flags("logic flags", fl[i], flags, 5'h0a);
			chk_flags("to memory", 5'h01, {4'h0, to_mem}, 5'h01);
		end
		@(negedge clk_i);
		chk_word("memory copy", 16'hf878, mem_a);
		chk_word("register kept", 16'h1234, reg_a);
		$display("logic and shift test done");
	endtask : t_logic
	task automatic t_mul();
		logic [31:0] pr [6] = '{32'h0000_0002, 32'hfffd_0002, 32'hfffe_0002, 32'hffff_ffe1, 32'h001e_ffe1,
			32'h0000_fd02};
		for (int i = 0; i < 6; i++) begin
			run_op(OP_MUL, 4'h0, 3'(i), 5'h1f, 16'hffff, 16'hfffe, 16'h0000, 16'h0000);
			chk_word("product low", pr[i][15:0], result_o);
			chk_word("product high", pr[i][31:16], result_hi_o);
			chk_word("mul latency", 16'h0002, 16'(lat));
			chk_flags("mul busy", 5'h01, {4'h0, saw_busy}, 5'h01);
		end
		$display("multiply test done");
	endtask : t_mul
	task automatic t_div();
		run_op(OP_DIVU, 4'h2, 3'h0, 5'h00, 16'h0007, 16'h0002, 16'h0000, 16'h0000);
		chk_word("quotient", 16'h0003, result_o);
		chk_word("remainder", 16'h0001, result_hi_o);
		chk_word("div latency", 16'h0012, 16'(lat));
		chk_flags("div flags", 5'h00, flags, 5'h0a);
		run_op(OP_DIVS, 4'h2, 3'h0, 5'h00, 16'h0001, 16'h0002, 16'h0000, 16'h0000);
		chk_word("zero quotient", 16'h0000, result_o);
		chk_word("signed remainder", 16'h0001, result_hi_o);
		chk_flags("zero div flags", 5'h02, flags, 5'h0a);
		$display("divide test done");
	endtask : t_div
	task automatic t_bus();
		int n0;
		wb_xfer({28'h0000000, REG_OPA}, 1'h1, 32'h0000_0003, 4'hf);
		wb_xfer({28'h0000000, REG_OPB}, 1'h1, 32'h0000_0004, 4'hf);
		wb_xfer({28'h0000000, REG_OPA}, 1'h0, 32'h0000_0000, 4'hf);
		chk_word("operand readback", 16'h0003, rd[15:0]);
		n0 = n_res;
		wb_xfer({28'h0000000, REG_CTRL}, 1'h1, {28'h0000000, OP_SUB}, 4'h1);
		for (int n = 0; n < 40 && n_res == n0; n++) begin
			@(posedge clk_i);
		end
		if (n_res == n0) give_up("software result");
		chk_word("software diff", 16'hffff, last_res);
		chk_flags("software dest", 5'h01, {4'h0, last_reg}, 5'h01);
		wb_xfer({28'h0000000, REG_FLAGS}, 1'h0, 32'h0000_0000, 4'hf);
		chk_flags("flags read", 5'h08, rd[4:0], 5'h1f);
		wb_xfer(32'h0000_0010, 1'h0, 32'h0000_0000, 4'hf);
		chk_flags("unmapped error", 5'h01, {4'h0, err}, 5'h01);
		$display("register bus test done");
	endtask : t_bus
	// ==========================================
	// Main sequence
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'h0;
		t_arith();
		t_logic();
		t_mul();
		t_div();
		t_bus();
		close_out();
	end
endmodule : test_cpu_alu_with_multiplier
